// ==== hdl/ascii_filter_alarm_cmd.sv ====
// ASCII command interpreter for input filter widths, trigger levels and alarms
// Summary of operation
// - High pulses shorter than the minimum high width are dropped as noise.
// - Low pulses shorter than the minimum low width are dropped as noise.
// - Widths are four decimal digits in microseconds, 4 to 1020.
// - High width code without data returns marker, address, stored four digits, CR.
// - Low width code without data returns marker, address, stored four digits, CR.
// - High threshold code with two digits stores level in 0.1 V, 0.1 to 5 V.
// - High threshold code without data returns the two stored digits.
// - Low threshold code with two digits stores low level, same encoding.
// - Low threshold code without data returns the two stored digits.
// - Alarm enable: '@', address, alarm code, digit 0 or 1 picks counter, CR.
// - An enabled alarm drives its output once the counter reaches its limit.
// - Accepted set or enable answers '!' and address; invalid answers '?'.
// - The address is exactly two characters right after the leading code.
// - Each alarm limit is eight hex digits, one code per counter.
`timescale 1ns/1ps
`default_nettype none
`include "filt_alarm_defs.svh"
module ascii_filter_alarm_cmd
  import filt_alarm_pkg::*;
(
  // Clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // AHB-Lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic [31:0]          hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  // Signal input
  input  wire logic            raw_in,
  output logic                 filtered_level,
  // Comparator trigger levels in 0.1 V
  output logic [5:0]           high_threshold,
  output logic [5:0]           low_threshold,
  // Counters and alarm outputs
  input  wire logic [1:0][31:0] counter_value,
  output logic [1:0]           alarm_out
);
  cmd_state_t                  q;
  cmd_state_t                  d;
  reply_if                     rif ();
  logic                        addr_ph;
  logic                        frame_end;
  logic                        addr_ok;
  logic                        ok;
  logic                        dec_all;
  logic                        hex_all;
  logic                        counter_select;
  logic [15:0]                 code;
  logic [15:0]                 min_width_field;
  logic [7:0]                  trigger_level_field;
  logic [31:0]                 alarm_limit_field;
  logic [15:0]                 rd_bcd;
  logic [3:0]                  dn;
  logic [0:`REPLY_MAX-1][7:0]  rc;
  logic [15:0]                 hi_cyc;
  logic [15:0]                 lo_cyc;
  char_t                       ch;

  assign hi_cyc = 16'(bcd4_bin(q.hi_w) * `CYC_PER_US);
  assign lo_cyc = 16'(bcd4_bin(q.lo_w) * `CYC_PER_US);

  pulse_filter u_filter (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .raw_in    (raw_in),
    .hi_cycles (hi_cyc),
    .lo_cycles (lo_cyc),
    .level     (filtered_level)
  );

  reply_tx u_reply (
    .hclk    (hclk),
    .hresetn (hresetn),
    .rif     (rif.sink)
  );

  always_comb begin
    d = q;
    ch = hwdata[7:0];
    frame_end = 1'b0;
    ok = 1'b0;
    dn = '0;
    rd_bcd = '0;
    rc = '0;
    rif.pop = 1'b0;
    // Bus side: zero wait states, read data captured in the address phase
    addr_ph = hsel && htrans[1] && hready;
    d.wr_rx = addr_ph && hwrite && (haddr == `RX_OFS);
    d.wr_adr = addr_ph && hwrite && (haddr == `ADDR_OFS);
    d.hreadyout = 1'b1;
    d.hresp = 1'b0;
    d.hrdata = '0;
    if (addr_ph && !hwrite) begin
      case (haddr)
        `TX_OFS: begin
          d.hrdata = 32'({rif.avail, rif.cur});
          rif.pop = rif.avail;
        end
        `STAT_OFS: d.hrdata = 32'({q.alarm_en, q.alarm_out, filtered_level, rif.avail});
        `ADDR_OFS: d.hrdata = 32'(q.my_addr);
        default:   d.hrdata = '0;
      endcase
    end
    if (q.wr_adr) begin
      d.my_addr = hwdata[15:0];
    end

    // Frame collection; a leading code always restarts a frame
    if (q.wr_rx) begin
      if ((ch == `CH_DOLLAR) || (ch == `CH_AT)) begin
        d.st = ST_BODY;
        d.lead = ch;
        d.cnt = '0;
        d.ovf = 1'b0;
      end else if ((q.st != ST_IDLE) && (ch == `CH_CR)) begin
        d.st = ST_IDLE;
        frame_end = 1'b1;
      end else if (q.st == ST_BODY) begin
        if (q.cnt == `FRAME_MAX) begin
          d.st = ST_SKIP;
          d.ovf = 1'b1;
        end else begin
          d.fbuf[q.cnt] = ch;
          d.cnt = q.cnt + 4'h1;
        end
      end
    end

    // Decode of the finished frame
    code = {q.fbuf[2], q.fbuf[3]};
    addr_ok = (q.cnt >= `N_ADDR) && ({q.fbuf[0], q.fbuf[1]} == q.my_addr);
    dec_all = 1'b1;
    hex_all = 1'b1;
    alarm_limit_field = '0;
    for (int i = 4; i < `FRAME_MAX; i++) begin
      if (i < q.cnt) begin
        dec_all = dec_all && is_dec(q.fbuf[i]);
        hex_all = hex_all && is_hex(q.fbuf[i]);
      end
      alarm_limit_field = {alarm_limit_field[27:0], nib(q.fbuf[i])};
    end
    min_width_field = {nib(q.fbuf[4]), nib(q.fbuf[5]), nib(q.fbuf[6]), nib(q.fbuf[7])};
    trigger_level_field = {nib(q.fbuf[4]), nib(q.fbuf[5])};
    counter_select = q.fbuf[4][0];

    if (frame_end && addr_ok && !q.ovf) begin
      if (q.lead == `CH_DOLLAR) begin
        case (code)
          `HIGH_WIDTH_CODE, `LOW_WIDTH_CODE: begin
            if (q.cnt == `N_READ) begin
              // Stored digits are sent back as kept
              ok = 1'b1;
              dn = `D_WIDTH;
              rd_bcd = (code == `HIGH_WIDTH_CODE) ? q.hi_w : q.lo_w;
            end else if ((q.cnt == `N_SET_W) && dec_all &&
                         (bcd4_bin(min_width_field) >= `W_MIN) &&
                         (bcd4_bin(min_width_field) <= `W_MAX)) begin
              ok = 1'b1;
              if (code == `HIGH_WIDTH_CODE) begin
                d.hi_w = min_width_field;
              end else begin
                d.lo_w = min_width_field;
              end
            end
          end
          `HIGH_THRESHOLD_CODE, `LOW_THRESHOLD_CODE: begin
            if (q.cnt == `N_READ) begin
              ok = 1'b1;
              dn = `D_THR;
              rd_bcd = (code == `HIGH_THRESHOLD_CODE) ? {q.hi_t, 8'h00} : {q.lo_t, 8'h00};
            end else if ((q.cnt == `N_SET_T) && dec_all &&
                         (bcd2_bin(trigger_level_field) >= `T_MIN) &&
                         (bcd2_bin(trigger_level_field) <= `T_MAX)) begin
              ok = 1'b1;
              if (code == `HIGH_THRESHOLD_CODE) begin
                d.hi_t = trigger_level_field;
                d.hi_tb = 6'(bcd2_bin(trigger_level_field));
              end else begin
                d.lo_t = trigger_level_field;
                d.lo_tb = 6'(bcd2_bin(trigger_level_field));
              end
            end
          end
          default: ok = 1'b0;
        endcase
      end else begin
        case (code)
          `ALARM_ON_CODE: begin
            if ((q.cnt == `N_EA) &&
                ((q.fbuf[4] == `CH_ZERO) || (q.fbuf[4] == `CH_ONE))) begin
              ok = 1'b1;
              d.alarm_en[counter_select] = 1'b1;
            end
          end
          `LIMIT0_SET_CODE, `LIMIT1_SET_CODE: begin
            if ((q.cnt == `N_LIMIT) && hex_all) begin
              ok = 1'b1;
              d.limit[code == `LIMIT1_SET_CODE] = alarm_limit_field;
            end
          end
          default: ok = 1'b0;
        endcase
      end
    end

    // Reply: marker, echoed address, optional digits, CR
    rc[0] = ok ? `CH_OK : `CH_BAD;
    rc[1] = q.fbuf[0];
    rc[2] = q.fbuf[1];
    for (int i = 0; i < 4; i++) begin
      if (i < dn) begin
        rc[3 + i] = `CH_ZERO | {4'h0, rd_bcd[15 - 4 * i -: 4]};
      end
    end
    rc[3 + dn] = `CH_CR;
    rif.chars = rc;
    rif.len = `REPLY_FIXED + dn;
    rif.load = frame_end && addr_ok;

    // Alarm compare; disabling is not handled here, so an enable is sticky
    for (int i = 0; i < 2; i++) begin
      d.alarm_out[i] = q.alarm_en[i] && (counter_value[i] >= q.limit[i]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.hreadyout <= 1'b1;
      q.my_addr <= `ADDR_RST;
      q.hi_w <= `HI_W_RST;
      q.lo_w <= `LO_W_RST;
      q.hi_t <= `HI_T_RST;
      q.lo_t <= `LO_T_RST;
      q.hi_tb <= `HI_T_BIN_RST;
      q.lo_tb <= `LO_T_BIN_RST;
    end else begin
      q <= d;
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp = q.hresp;
  assign high_threshold = q.hi_tb;
  assign low_threshold = q.lo_tb;
  assign alarm_out = q.alarm_out;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_alarm_reach: assert property (q.alarm_en[0] && (counter_value[0] >= q.limit[0])
    |=> alarm_out[0])
    else $error("enabled alarm 0 not raised at its limit");
  a_alarm_idle: assert property (!q.alarm_en[1] |=> !alarm_out[1])
    else $error("alarm 1 raised while not enabled");
  a_width_range: assert property ((bcd4_bin(q.hi_w) >= `W_MIN) &&
    (bcd4_bin(q.hi_w) <= `W_MAX) &&
    (bcd4_bin(q.lo_w) <= `W_MAX) && (bcd4_bin(q.lo_w) >= `W_MIN))
    else $error("stored width out of range");
  a_thr_range: assert property ((q.hi_tb >= 6'(`T_MIN)) && (q.hi_tb <= 6'(`T_MAX)))
    else $error("stored high trigger level out of range");
  a_low_thr_range: assert property ((q.lo_tb >= 6'(`T_MIN)) &&
    (q.lo_tb <= 6'(`T_MAX)))
    else $error("stored low trigger level out of range");
  a_foreign_quiet: assert property (frame_end && !addr_ok |-> !rif.load)
    else $error("reply sent to a foreign address");
  a_reply_marker: assert property (frame_end && addr_ok |->
    rif.load && (rif.chars[0] == (ok ? `CH_OK : `CH_BAD)) && (rif.chars[1] == q.fbuf[0]))
    else $error("reply marker or address wrong");
  a_reject_keep: assert property (frame_end && !ok |=>
    $stable(q.hi_w) && $stable(q.lo_w) && $stable(q.hi_t) && $stable(q.lo_t))
    else $error("refused frame changed a setting");
  a_high_readback: assert property (frame_end && addr_ok && (q.lead == `CH_DOLLAR) &&
    (code == `HIGH_WIDTH_CODE) && (q.cnt == `N_READ) |->
    (rif.len == 4'h8) && (rif.chars[3] == (`CH_ZERO | {4'h0, q.hi_w[15:12]})) ##1 rif.avail)
    else $error("high width readback wrong");
  a_low_readback: assert property (frame_end && addr_ok && (q.lead == `CH_DOLLAR) &&
    (code == `LOW_WIDTH_CODE) && (q.cnt == `N_READ) |->
    rif.chars[6] == (`CH_ZERO | {4'h0, q.lo_w[3:0]}))
    else $error("low width readback wrong");

  c_alarm_rise: cover property (!alarm_out[0] ##1 alarm_out[0]);
  c_set_accept: cover property (frame_end && ok && (q.cnt == `N_SET_W));
  c_refused: cover property (frame_end && addr_ok && !ok);
  c_limit_set: cover property (frame_end && ok && (code == `LIMIT1_SET_CODE));
  c_overflow_refused: cover property (frame_end && addr_ok && q.ovf);
endmodule
`default_nettype wire

// ==== shared/filt_alarm_defs.svh ====
// Offsets, characters, codes, ranges and reset values of the filter and alarm command block
`ifndef FILT_ALARM_DEFS_SVH
`define FILT_ALARM_DEFS_SVH

`define CLK_PERIOD_NS   25
`define CYC_PER_US      (1000 / `CLK_PERIOD_NS)

`define RX_OFS          32'h0000_0000
`define TX_OFS          32'h0000_0004
`define STAT_OFS        32'h0000_0008
`define ADDR_OFS        32'h0000_000C

`define CH_CR           8'h0D
`define CH_OK           8'h21
`define CH_BAD          8'h3F
`define CH_DOLLAR       8'h24
`define CH_AT           8'h40
`define CH_ZERO         8'h30
`define CH_ONE          8'h31
`define CH_NINE         8'h39
`define CH_HEX_A        8'h41
`define CH_HEX_F        8'h46
`define HEX_A_BIAS      8'h37

`define HIGH_WIDTH_CODE     16'h3048
`define LOW_WIDTH_CODE      16'h304C
`define HIGH_THRESHOLD_CODE 16'h3148
`define LOW_THRESHOLD_CODE  16'h314C
`define ALARM_ON_CODE       16'h4541
`define LIMIT0_SET_CODE     16'h5041
`define LIMIT1_SET_CODE     16'h5341

`define W_MIN           14'h0004
`define W_MAX           14'h03FC
`define T_MIN           7'h01
`define T_MAX           7'h32

`define N_ADDR          4'h2
`define N_READ          4'h4
`define N_EA            4'h5
`define N_SET_T         4'h6
`define N_SET_W         4'h8
`define N_LIMIT         4'hC
`define FRAME_MAX       4'hC
`define D_WIDTH         4'h4
`define D_THR           4'h2
`define REPLY_FIXED     4'h4
`define REPLY_MAX       8

`define ADDR_RST        16'h3031
`define HI_W_RST        16'h0004
`define LO_W_RST        16'h0004
`define HI_T_RST        8'h24
`define LO_T_RST        8'h08
`define HI_T_BIN_RST    6'h18
`define LO_T_BIN_RST    6'h08

`endif

// ==== shared/filt_alarm_pkg.sv ====
// Types and character helpers of the filter and alarm command block
`default_nettype none
`include "filt_alarm_defs.svh"
package filt_alarm_pkg;

  typedef logic [7:0] char_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BODY = 3'b010,
    ST_SKIP = 3'b100
  } parse_st_t;

  typedef struct packed {
    parse_st_t                        st;
    char_t                            lead;
    logic [0:`FRAME_MAX-1][7:0]       fbuf;
    logic [3:0]                       cnt;
    logic                             ovf;
    logic                             wr_rx;
    logic                             wr_adr;
    logic [31:0]                      hrdata;
    logic                             hreadyout;
    logic                             hresp;
    logic [15:0]                      my_addr;
    logic [15:0]                      hi_w;
    logic [15:0]                      lo_w;
    logic [7:0]                       hi_t;
    logic [7:0]                       lo_t;
    logic [5:0]                       hi_tb;
    logic [5:0]                       lo_tb;
    logic [1:0]                       alarm_en;
    logic [1:0][31:0]                 limit;
    logic [1:0]                       alarm_out;
  } cmd_state_t;

  typedef struct packed {
    logic                             sync1;
    logic                             sync2;
    logic                             level;
    logic [15:0]                      cnt;
  } filt_state_t;

  typedef struct packed {
    logic [0:`REPLY_MAX-1][7:0]       chars;
    logic [3:0]                       len;
    logic [3:0]                       idx;
  } tx_state_t;

  function automatic logic is_dec(input char_t c);
    return (c >= `CH_ZERO) && (c <= `CH_NINE);
  endfunction

  function automatic logic is_hex(input char_t c);
    return is_dec(c) || ((c >= `CH_HEX_A) && (c <= `CH_HEX_F));
  endfunction

  function automatic logic [3:0] nib(input char_t c);
    char_t v;
    v = is_dec(c) ? c - `CH_ZERO : c - `HEX_A_BIAS;
    return v[3:0];
  endfunction

  function automatic logic [13:0] bcd4_bin(input logic [15:0] b);
    return 14'(b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0]);
  endfunction

  function automatic logic [6:0] bcd2_bin(input logic [7:0] b);
    return 7'(b[7:4] * 10 + b[3:0]);
  endfunction

endpackage
`default_nettype wire

// ==== shared/reply_if.sv ====
// Reply hand-off between the frame parser and the reply reader
`timescale 1ns/1ps
`default_nettype none
`include "filt_alarm_defs.svh"
interface reply_if;
  import filt_alarm_pkg::*;
  logic                       load;
  logic [0:`REPLY_MAX-1][7:0] chars;
  logic [3:0]                 len;
  logic                       pop;
  char_t                      cur;
  logic                       avail;
  modport src  (output load, chars, len, pop, input cur, avail);
  modport sink (input load, chars, len, pop, output cur, avail);
endinterface
`default_nettype wire

// ==== hdl/pulse_filter.sv ====
// Glitch filter that drops high and low pulses shorter than their minimum widths
`timescale 1ns/1ps
`default_nettype none
`include "filt_alarm_defs.svh"
module pulse_filter
  import filt_alarm_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Pin and widths in clock cycles
  input  wire logic        raw_in,
  input  wire logic [15:0] hi_cycles,
  input  wire logic [15:0] lo_cycles,
  // Filtered level
  output logic             level
);
  filt_state_t q;
  filt_state_t d;

  always_comb begin
    d = q;
    d.sync1 = raw_in;
    d.sync2 = q.sync1;
    if (q.sync2 == q.level) begin
      d.cnt = '0;
    end else if (q.cnt + 16'h0001 >= (q.sync2 ? hi_cycles : lo_cycles)) begin
      // Level held long enough to count as real
      d.level = q.sync2;
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.level;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_high_min_width: assert property ($rose(q.level) |->
    $past(q.sync2) && ($past(q.cnt) + 16'h0001 >= $past(hi_cycles)))
    else $error("high level accepted before its minimum width");
  a_low_min_width: assert property ($fell(q.level) |->
    !$past(q.sync2) && ($past(q.cnt) + 16'h0001 >= $past(lo_cycles)))
    else $error("low level accepted before its minimum width");
endmodule
`default_nettype wire

// ==== hdl/reply_tx.sv ====
// Holds one reply and hands it out a character at a time
`timescale 1ns/1ps
`default_nettype none
`include "filt_alarm_defs.svh"
module reply_tx
  import filt_alarm_pkg::*;
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Reply stream
  reply_if.sink     rif
);
  tx_state_t q;
  tx_state_t d;

  always_comb begin
    d = q;
    // A new reply replaces any unread remainder of the old one
    if (rif.load) begin
      d.chars = rif.chars;
      d.len = rif.len;
      d.idx = '0;
    end else if (rif.pop && (q.idx < q.len)) begin
      d.idx = q.idx + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rif.cur = q.chars[q.idx[2:0]];
  assign rif.avail = q.idx < q.len;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_pop_advance: assert property (rif.pop && rif.avail && !rif.load |=>
    q.idx == $past(q.idx) + 4'h1)
    else $error("reply pointer did not advance on a read");
  a_load_restart: assert property (rif.load |=> (q.idx == 4'h0) && rif.avail)
    else $error("new reply not presented from its first character");
endmodule
`default_nettype wire

// ==== bench/host_model.sv ====
// Host side: AHB-Lite master that writes command frames and reads replies
`timescale 1ns/1ps
`default_nettype none
`include "filt_alarm_defs.svh"
module host_model (
  // Clock
  input  wire logic        hclk,
  // AHB-Lite master
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // One single word transfer; no wait count assumed, the bench watchdog ends a hang
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    // Released data is scrambled so a stale value never looks valid
    hwdata <= ~d;
  endtask

  // Characters go out one per write, carriage return last
  task automatic frame(input string f);
    logic [31:0] r;
    for (int i = 0; i < f.len(); i++) begin
      xfer(`RX_OFS, 1'b1, {24'h0, f[i]}, r);
    end
    xfer(`RX_OFS, 1'b1, {24'h0, `CH_CR}, r);
    repeat (3) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_ascii_filter_alarm_cmd.sv ====
// Self-checking bench for the ASCII filter and alarm command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "filt_alarm_defs.svh"
module tb_ascii_filter_alarm_cmd;
  logic             hclk;
  logic             hresetn;
  logic             hsel;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  logic [31:0]      hrdata;
  logic             hreadyout;
  logic             hresp;
  logic             raw_in;
  logic             filtered_level;
  logic [5:0]       high_threshold;
  logic [5:0]       low_threshold;
  logic [1:0][31:0] counter_value;
  logic [1:0]       alarm_out;
  int               err_total;
  int               samples_checked;
  logic [31:0]      wr_r;
  string            bad[9];

  ascii_filter_alarm_cmd uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .raw_in(raw_in),
    .filtered_level(filtered_level), .high_threshold(high_threshold),
    .low_threshold(low_threshold), .counter_value(counter_value), .alarm_out(alarm_out)
  );

  host_model host (
    .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata)
  );

  always #12.5 hclk = ~hclk;

  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] mask, input logic [31:0] want);
    logic [31:0] r;
    host.xfer(a, 1'b0, 32'h0, r);
    check(r & mask, want);
  endtask

  // Empty reply text means no reply may appear at all
  task automatic cmd(input string f, input string rep);
    int n;
    n = rep.len() > 0 ? rep.len() + 1 : 0;
    host.frame(f);
    for (int i = 0; i < n; i++) begin
      rd(`TX_OFS, 32'h1FF, {23'h0, 1'b1, (i < rep.len()) ? rep[i] : `CH_CR});
    end
    rd(`TX_OFS, 32'h100, 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    stop_test();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    raw_in = 1'b0;
    counter_value = '0;
    err_total = 0;
    samples_checked = 0;
    bad = '{"$010H0003", "$010H1021", "$010H01A0", "$011H51", "$011H00", "$011L3X",
            "@01EA2", "@010H", "$01EA0"};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({26'h0, high_threshold}, 32'h18);
    check({26'h0, low_threshold}, 32'h8);
    check({30'h0, alarm_out}, 32'h0);
    check({30'h0, hreadyout, hresp}, 32'h2);
    rd(`ADDR_OFS, 32'hFFFF, 32'h3031);
    rd(32'h10, 32'hFFFFFFFF, 32'h0);
    cmd("$010H", "!010004");
    cmd("$010H0100", "!01");
    cmd("$010H", "!010100");
    cmd("$010L0010", "!01");
    cmd("$010L", "!010010");
    foreach (bad[i]) begin
      cmd(bad[i], "?01");
    end
    cmd("$010H", "!010100");
    cmd("$011L", "!0108");
    cmd("$010H1020", "!01");
    cmd("$010H", "!011020");
    cmd("$011H30", "!01");
    check({26'h0, high_threshold}, 32'h1E);
    cmd("$011H", "!0130");
    cmd("$011L10", "!01");
    check({26'h0, low_threshold}, 32'hA);
    cmd("$011L", "!0110");
    cmd("$020H", "");
    cmd("$0", "");
    counter_value[0] <= 32'h0000000F;
    counter_value[1] <= 32'h0002FFFF;
    cmd("@01PA00000010", "!01");
    cmd("@01SA0002FFFF", "!01");
    cmd("@01EA0", "!01");
    check({30'h0, alarm_out}, 32'h0);
    counter_value[0] <= 32'h00000010;
    repeat (3) @(posedge hclk);
    check({30'h0, alarm_out}, 32'h1);
    cmd("@01EA1", "!01");
    check({30'h0, alarm_out}, 32'h3);
    rd(`STAT_OFS, 32'h30, 32'h30);
    // Filter widths: high 4 us is 160 cycles, low 10 us is 400 cycles
    cmd("$010H0004", "!01");
    raw_in <= 1'b1;
    repeat (100) @(posedge hclk);
    check({31'h0, filtered_level}, 32'h0);
    raw_in <= 1'b0;
    repeat (20) @(posedge hclk);
    check({31'h0, filtered_level}, 32'h0);
    raw_in <= 1'b1;
    repeat (200) @(posedge hclk);
    check({31'h0, filtered_level}, 32'h1);
    raw_in <= 1'b0;
    repeat (300) @(posedge hclk);
    check({31'h0, filtered_level}, 32'h1);
    raw_in <= 1'b1;
    repeat (20) @(posedge hclk);
    check({31'h0, filtered_level}, 32'h1);
    raw_in <= 1'b0;
    repeat (450) @(posedge hclk);
    check({31'h0, filtered_level}, 32'h0);
    // Alarms, enables and idle level seen through the status word
    rd(`STAT_OFS, 32'h3F, 32'h3C);
    // New address: the old one goes quiet, the new one answers
    host.xfer(`ADDR_OFS, 1'b1, 32'h3032, wr_r);
    rd(`ADDR_OFS, 32'hFFFF, 32'h3032);
    cmd("$010H", "");
    cmd("$020H", "!020004");
    // Thirteen body characters overflow the frame
    cmd("$020H000000000", "?02");
    stop_test();
  end
endmodule
`default_nettype wire
